// File: src/reset_ctrl_pkg.sv
// constants, register map and reset values of the system reset controller
//
// What this block does
// - any reset aborts the current instruction and reinitialises the break flag enable and interrupt mask bits
// - reset vector fetched from FFFE/FFFF, or FEFE/FEFF in monitor mode
// - reset selects oscillator clock divided by four as bus clock
// - normal operation: bus clock is clock generator output divided by two
// - reset pin held low minimum time causes external reset, sets pin flag
// - internal resets drive pin low 32 cycles, then hold reset 32 more
// - power-on reset is internal, from supply rise, only a power-up event
// - watchdog overflow causes internal reset and sets watchdog flag
// - watchdog disabled only by test high voltage in monitor or break state
// - illegal instruction decode sets illegal opcode flag and resets
// - stop instruction with stop-enable clear is an illegal opcode
// - opcode fetch from unmapped address sets illegal address flag and resets
// - low-voltage monitor output sets low-voltage flag and holds pin low
// - cause register bits 7..1: por,pin,wdog,illegal_opcode_flag,illegal_address_flag,monitor_mode_reset_flag,lvi; bit0 zero
package reset_ctrl_pkg;

  localparam logic [15:0] ADDR_BREAK_STATUS  = 16'hFE00;
  localparam logic [15:0] ADDR_RESET_CAUSE   = 16'hFE01;
  localparam logic [15:0] ADDR_BREAK_FLAG    = 16'hFE03;
  localparam logic [15:0] ADDR_INT_FIRST     = 16'hFE04;
  localparam logic [15:0] ADDR_INT_SECOND    = 16'hFE05;
  localparam logic [15:0] ADDR_INT_THIRD     = 16'hFE06;
  localparam logic [15:0] ADDR_IRQ_STATUS    = 16'hFE10;
  localparam logic [15:0] ADDR_IRQ_MASK      = 16'hFE11;
  localparam logic [15:0] ADDR_CONFIG        = 16'hFE12;

  localparam logic [7:0] RESET_CAUSE_POR_VAL = 8'h80;
  localparam logic [7:0] BREAK_STATUS_RST    = 8'h00;
  localparam logic [7:0] CONFIG_RST          = 8'h00;

  localparam int CAUSE_POR    = 7;
  localparam int CAUSE_PIN    = 6;
  localparam int CAUSE_WDOG   = 5;
  localparam int CAUSE_ILLEGAL_OPCODE_FLAG   = 4;
  localparam int CAUSE_ILLEGAL_ADDRESS_FLAG   = 3;
  localparam int CAUSE_MONITOR_MODE_RESET_FLAG = 2;
  localparam int CAUSE_LVI    = 1;
  localparam int BRK_WAIT_BIT = 1;
  localparam int BREAK_CLEAR_FLAG_ENABLE_BIT     = 7;
  localparam int CFG_STOPEN   = 0;

  localparam logic [15:0] VEC_NORMAL  = 16'hFFFE;
  localparam logic [15:0] VEC_MONITOR = 16'hFEFE;

  localparam int          PIN_LOW_OSC_CYCLES  = 32;
  localparam int          HOLD_OSC_CYCLES     = 32;
  localparam logic [6:0]  PIN_LOW_CNT         = 7'(PIN_LOW_OSC_CYCLES);
  localparam logic [6:0]  TOTAL_CNT           = 7'(PIN_LOW_OSC_CYCLES + HOLD_OSC_CYCLES);
  // minimum external low time, in oscillator cycles (filter length)
  localparam int          RESET_LOW_TIME_CYC  = 4;
  localparam logic [2:0]  EXT_LOW_CNT         = 3'(RESET_LOW_TIME_CYC);

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_DRIVE = 3'b010,
    ST_HOLD  = 3'b100
  } rst_state_t;

endpackage

// File: src/system_reset_controller.sv
// system reset controller: reset sources, pin stretch, cause register, bus clock select
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module system_reset_controller
  import reset_ctrl_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  // reset sources
  input  wire logic        POR_I,
  input  wire logic        WDOG_OVF_I,
  input  wire logic        LVI_I,
  input  wire logic        ILLEGAL_OP_I,
  input  wire logic        STOP_OP_I,
  input  wire logic        OPCODE_FETCH_I,
  input  wire logic        UNMAPPED_I,
  input  wire logic        MONITOR_MODE_I,
  input  wire logic        MONITOR_RST_I,
  input  wire logic        BREAK_STATE_I,
  input  wire logic        RST_PIN_VTST_I,
  input  wire logic        IRQ_PIN_VTST_I,
  input  wire logic        WAIT_BREAK_I,
  input  wire logic [7:0]  INT_FLAGS1_I,
  input  wire logic [7:0]  INT_FLAGS2_I,
  input  wire logic [7:0]  INT_FLAGS3_I,
  input  wire logic        CLK_SRC_PLL_I,
  // reset pin, open drain
  input  wire logic        RST_PIN_I,
  output logic             RST_PIN_O,
  output logic             RST_PIN_OE_N_O,
  // core side
  output logic             CORE_RESET_O,
  output logic [15:0]      RESET_VECTOR_O,
  output logic [1:0]       BUS_CLK_SEL_O,
  output logic             WDOG_DISABLE_O,
  output logic             IRQ_O,
  // avalon-mm slave
  input  wire logic [15:0] AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [7:0]  AVS_WRITEDATA_I,
  output logic [7:0]       AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O
);

  //////////////////////////////////////////////////////////////////////////////
  rst_state_t state_reg;
  logic [6:0] cnt_reg;
  logic [2:0] ext_cnt_reg;
  logic       ext_seen_reg;
  logic [7:0] cause_reg;
  logic [7:0] brk_reg;
  logic [7:0] break_clear_flag_enable_reg;
  logic [7:0] cfg_reg;
  logic [7:0] irq_stat_reg;
  logic [7:0] irq_mask_reg;
  logic       ack_reg;
  logic [7:0] ev_cause;
  logic       internal_ev;
  logic       ext_ev;
  logic       wr_en;
  logic       rd_en;

  assign wr_en = AVS_WRITE_I & ~ack_reg;
  assign rd_en = AVS_READ_I & ~ack_reg;

  always_comb begin
    ev_cause = 8'h00;
    ev_cause[CAUSE_POR] = POR_I;
    ev_cause[CAUSE_WDOG] = WDOG_OVF_I;
    ev_cause[CAUSE_ILLEGAL_OPCODE_FLAG] = ILLEGAL_OP_I | (STOP_OP_I & ~cfg_reg[CFG_STOPEN]);
    ev_cause[CAUSE_ILLEGAL_ADDRESS_FLAG] = OPCODE_FETCH_I & UNMAPPED_I;
    ev_cause[CAUSE_MONITOR_MODE_RESET_FLAG] = MONITOR_RST_I;
    ev_cause[CAUSE_LVI] = LVI_I;
  end

  assign internal_ev = |ev_cause;
  // external reset after minimum low time, not while we drive the pin
  assign ext_ev = (ext_cnt_reg == EXT_LOW_CNT) & ~ext_seen_reg & (state_reg == ST_RUN);

  //////////////////////////////////////////////////////////////////////////////
  // external low-time filter
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ext_cnt_reg  <= 3'h0;
      ext_seen_reg <= 1'b0;
    end else if (RST_PIN_I) begin
      ext_cnt_reg  <= 3'h0;
      ext_seen_reg <= 1'b0;
    end else if (ext_cnt_reg != EXT_LOW_CNT) begin
      ext_cnt_reg <= ext_cnt_reg + 3'h1;
    end else begin
      ext_seen_reg <= 1'b1;
    end
  end

  // stretch sequence: drive pin, then hold core
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_reg <= ST_DRIVE;
      cnt_reg   <= 7'h00;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          cnt_reg <= 7'h00;
          if (internal_ev) begin
            state_reg <= ST_DRIVE;
            // the edge that sees the cause already drives the pin, so it counts as one
            cnt_reg   <= 7'h01;
          end else if (ext_ev) begin
            state_reg <= ST_HOLD;
            // the edge that takes the filtered pin already holds the core
            cnt_reg   <= PIN_LOW_CNT + 7'h01;
          end
        end
        ST_DRIVE: begin
          cnt_reg <= cnt_reg + 7'h01;
          // low voltage keeps pin low while asserted
          if (cnt_reg == PIN_LOW_CNT - 7'h01 && !LVI_I && !POR_I) begin
            state_reg <= ST_HOLD;
          end else if (LVI_I || POR_I) begin
            cnt_reg <= 7'h00;
          end
        end
        ST_HOLD: begin
          cnt_reg <= cnt_reg + 7'h01;
          if (internal_ev) begin
            state_reg <= ST_DRIVE;
            cnt_reg   <= 7'h01;
          end else if (cnt_reg == TOTAL_CNT - 7'h01) begin
            state_reg <= ST_RUN;
          end
        end
      endcase
    end
  end

  // core held in reset during whole sequence; pin driven in drive phase
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      CORE_RESET_O   <= 1'b1;
      RST_PIN_O      <= 1'b0;
      RST_PIN_OE_N_O <= 1'b0;
    end else begin
      CORE_RESET_O   <= (state_reg != ST_RUN) | internal_ev | ext_ev;
      RST_PIN_O      <= 1'b0;
      RST_PIN_OE_N_O <= ~((state_reg == ST_DRIVE) | internal_ev);
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RESET_VECTOR_O <= VEC_NORMAL;
      BUS_CLK_SEL_O  <= 2'h0;
    end else begin
      RESET_VECTOR_O <= MONITOR_MODE_I ? VEC_MONITOR : VEC_NORMAL;
      // 0: osc/4 during reset; 1: osc-based output/2; 2: loop-based output/2
      if (state_reg != ST_RUN) begin
        BUS_CLK_SEL_O <= 2'h0;
      end else begin
        BUS_CLK_SEL_O <= CLK_SRC_PLL_I ? 2'h2 : 2'h1;
      end
    end
  end

  // watchdog disable only by test voltage qualified by mode
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      WDOG_DISABLE_O <= 1'b0;
    end else begin
      WDOG_DISABLE_O <= (MONITOR_MODE_I & (RST_PIN_VTST_I | IRQ_PIN_VTST_I))
                      | (BREAK_STATE_I & RST_PIN_VTST_I);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // cause register: power-on clears others, each later reset replaces it with its own causes
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cause_reg <= RESET_CAUSE_POR_VAL;
    end else if (POR_I) begin
      cause_reg <= RESET_CAUSE_POR_VAL;
    end else if (internal_ev | ext_ev) begin
      // new reset records only its own causes; a read in run state does not clear
      cause_reg <= {ev_cause[7], ext_ev, ev_cause[5:1], 1'b0};
    end
  end

  // break-during-wait flag, set wins over write-zero clear
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      brk_reg <= BREAK_STATUS_RST;
    end else if (WAIT_BREAK_I) begin
      brk_reg[BRK_WAIT_BIT] <= 1'b1;
    end else if (wr_en && AVS_ADDRESS_I == ADDR_BREAK_STATUS && !AVS_WRITEDATA_I[BRK_WAIT_BIT]) begin
      brk_reg[BRK_WAIT_BIT] <= 1'b0;
    end
  end

  // control bits except config reinitialised by any reset sequence
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      break_clear_flag_enable_reg     <= 8'h00;
      cfg_reg      <= CONFIG_RST;
      irq_mask_reg <= 8'h00;
    end else if (state_reg != ST_RUN) begin
      break_clear_flag_enable_reg     <= 8'h00;
      irq_mask_reg <= 8'h00;
    end else if (wr_en) begin
      if (AVS_ADDRESS_I == ADDR_BREAK_FLAG) break_clear_flag_enable_reg[BREAK_CLEAR_FLAG_ENABLE_BIT] <= AVS_WRITEDATA_I[BREAK_CLEAR_FLAG_ENABLE_BIT];
      if (AVS_ADDRESS_I == ADDR_CONFIG) cfg_reg <= AVS_WRITEDATA_I;
      if (AVS_ADDRESS_I == ADDR_IRQ_MASK) irq_mask_reg <= AVS_WRITEDATA_I;
    end
  end

  // sticky event status, write one clears, set wins
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_stat_reg <= 8'h00;
    end else begin
      irq_stat_reg <= (irq_stat_reg
                      & ~((wr_en && AVS_ADDRESS_I == ADDR_IRQ_STATUS) ? AVS_WRITEDATA_I : 8'h00))
                      | {ev_cause[7], ext_ev, ev_cause[5:1], 1'b0}
                      | {7'h00, WAIT_BREAK_I};
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus: one wait state, answer on second cycle of request
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ack_reg           <= 1'b0;
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O    <= 8'h00;
    end else begin
      ack_reg           <= (AVS_READ_I | AVS_WRITE_I) & ~ack_reg;
      AVS_WAITREQUEST_O <= ~((AVS_READ_I | AVS_WRITE_I) & ~ack_reg);
      if (rd_en) begin
        unique case (AVS_ADDRESS_I)
          ADDR_BREAK_STATUS: AVS_READDATA_O <= brk_reg;
          ADDR_RESET_CAUSE:  AVS_READDATA_O <= cause_reg;
          ADDR_BREAK_FLAG:   AVS_READDATA_O <= break_clear_flag_enable_reg;
          ADDR_INT_FIRST:    AVS_READDATA_O <= {INT_FLAGS1_I[7:2], 2'h0};
          ADDR_INT_SECOND:   AVS_READDATA_O <= INT_FLAGS2_I;
          ADDR_INT_THIRD:    AVS_READDATA_O <= {2'h0, INT_FLAGS3_I[5:0]};
          ADDR_IRQ_STATUS:   AVS_READDATA_O <= irq_stat_reg;
          ADDR_IRQ_MASK:     AVS_READDATA_O <= irq_mask_reg;
          ADDR_CONFIG:       AVS_READDATA_O <= cfg_reg;
          default:           AVS_READDATA_O <= 8'h00;
        endcase
      end
    end
  end

endmodule

// File: bench/system_reset_controller_chk.sv
// checker: port-level timing of the system reset controller
`timescale 1ns/1ps
module system_reset_controller_chk
  import reset_ctrl_pkg::*;
(
  input wire logic        CLK_I,
  input wire logic        RST_N_I,
  input wire logic        WDOG_OVF_I,
  input wire logic        LVI_I,
  input wire logic        MONITOR_MODE_I,
  input wire logic        BREAK_STATE_I,
  input wire logic        RST_PIN_VTST_I,
  input wire logic        IRQ_PIN_VTST_I,
  input wire logic        CLK_SRC_PLL_I,
  input wire logic        RST_PIN_OE_N_O,
  input wire logic        CORE_RESET_O,
  input wire logic [15:0] RESET_VECTOR_O,
  input wire logic [1:0]  BUS_CLK_SEL_O,
  input wire logic        WDOG_DISABLE_O
);
  int   lo_cnt;
  int   hi_cnt;
  logic vtst_ok;
  assign vtst_ok = MONITOR_MODE_I && (RST_PIN_VTST_I || IRQ_PIN_VTST_I)
                   || BREAK_STATE_I && RST_PIN_VTST_I;
  always_ff @(posedge CLK_I or negedge RST_N_I)
    if (!RST_N_I) lo_cnt <= 0;
    else lo_cnt <= RST_PIN_OE_N_O ? 0 : lo_cnt + 1;
  // hold phase: core still in reset after the pin was let go
  always_ff @(posedge CLK_I or negedge RST_N_I)
    if (!RST_N_I) hi_cnt <= 0;
    else hi_cnt <= (CORE_RESET_O && RST_PIN_OE_N_O) ? hi_cnt + 1 : 0;
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  wdog_reset_a: assert property (
    WDOG_OVF_I && !CORE_RESET_O |=> !RST_PIN_OE_N_O && CORE_RESET_O)
    else $error("watchdog overflow did not start a reset");
  pin_drive_a: assert property ($rose(RST_PIN_OE_N_O) |-> lo_cnt >= 32)
    else $error("reset pin released too early");
  core_hold_a: assert property ($fell(CORE_RESET_O) |-> hi_cnt == 32)
    else $error("core hold after pin release not 32 cycles");
  reset_clk_a: assert property (
    CORE_RESET_O && $past(CORE_RESET_O) |-> BUS_CLK_SEL_O == 2'h0)
    else $error("bus clock not osc/4 during reset");
  run_clk_a: assert property (
    !CORE_RESET_O && !$past(CORE_RESET_O) && !$past(CORE_RESET_O, 2)
    && $stable(CLK_SRC_PLL_I) |-> BUS_CLK_SEL_O == (CLK_SRC_PLL_I ? 2'h2 : 2'h1))
    else $error("bus clock select wrong in run");
  wdog_gate_a: assert property (WDOG_DISABLE_O |-> vtst_ok || $past(vtst_ok))
    else $error("watchdog disabled without test voltage");
  vector_sel_a: assert property (
    $fell(CORE_RESET_O) |-> RESET_VECTOR_O == (MONITOR_MODE_I ? VEC_MONITOR : VEC_NORMAL))
    else $error("reset vector wrong");
  lvi_pin_a: assert property (LVI_I [*2] |-> !RST_PIN_OE_N_O)
    else $error("pin not held low under low voltage");
endmodule

// File: bench/reset_source_model.sv
// far side: core decode strobes, on-chip reset sources and the reset pin wire
`timescale 1ns/1ps
module reset_source_model (
  input  wire logic [3:0] ev_i,
  input  wire logic       oe_n_i,
  output logic            por_o,
  output logic            wdog_o,
  output logic            lvi_o,
  output logic            illegal_opcode_flag_o,
  output logic            stop_o,
  output logic            fetch_o,
  output logic            unmapped_o,
  output logic            monitor_mode_reset_flag_o,
  output logic            pin_o
);
  assign por_o      = ev_i == 4'h1;
  assign wdog_o     = ev_i == 4'h2;
  assign lvi_o      = ev_i == 4'h3;
  assign illegal_opcode_flag_o     = ev_i == 4'h4;
  assign stop_o     = ev_i == 4'h5;
  assign fetch_o    = ev_i == 4'h6;
  assign unmapped_o = ev_i == 4'h6 || ev_i == 4'h7;
  assign monitor_mode_reset_flag_o   = ev_i == 4'h8;
  // outside party pulls low
  // open drain with pull-up: high unless either party pulls it low
  assign pin_o      = oe_n_i && ev_i != 4'h9;
endmodule

// File: bench/test_system_reset_controller.sv
// self-checking bench for the system reset controller
`timescale 1ns/1ps
module test_system_reset_controller;
  import reset_ctrl_pkg::*;
  logic CLK_I = 0, RST_N_I = 0, MONITOR_MODE_I = 0, RST_PIN_VTST_I = 0, CLK_SRC_PLL_I = 0;
  logic BREAK_STATE_I = 0, IRQ_PIN_VTST_I = 0, WAIT_BREAK_I = 0, AVS_READ_I = 0, AVS_WRITE_I = 0;
  logic [7:0] INT_FLAGS1_I = 8'h00, INT_FLAGS2_I = 8'h00, INT_FLAGS3_I = 8'h00;
  logic [7:0] AVS_WRITEDATA_I = 8'h00, AVS_READDATA_O, q;
  logic [15:0] AVS_ADDRESS_I = 16'h0000, RESET_VECTOR_O;
  logic [3:0] ev = 4'h0;
  logic [1:0] BUS_CLK_SEL_O;
  logic POR_I, WDOG_OVF_I, LVI_I, ILLEGAL_OP_I, STOP_OP_I, OPCODE_FETCH_I, UNMAPPED_I, IRQ_O;
  logic MONITOR_RST_I, RST_PIN_I, RST_PIN_O, RST_PIN_OE_N_O, CORE_RESET_O, WDOG_DISABLE_O;
  logic AVS_WAITREQUEST_O;
  int err_total = 0, compares = 0, cyc = 0;
  always #4 CLK_I = ~CLK_I;
  reset_source_model far (.ev_i(ev), .oe_n_i(RST_PIN_OE_N_O), .por_o(POR_I),
    .wdog_o(WDOG_OVF_I), .lvi_o(LVI_I), .illegal_opcode_flag_o(ILLEGAL_OP_I), .stop_o(STOP_OP_I),
    .fetch_o(OPCODE_FETCH_I), .unmapped_o(UNMAPPED_I), .monitor_mode_reset_flag_o(MONITOR_RST_I), .pin_o(RST_PIN_I));
  system_reset_controller uut (.*);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge CLK_I);
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= d;
    AVS_READ_I <= !wr;
    AVS_WRITE_I <= wr;
    // no wait-state count assumed; the cycle ceiling ends a hung transfer
    do begin
      @(posedge CLK_I);
    end while (AVS_WAITREQUEST_O !== 1'b0);
    q = AVS_READDATA_O;
    AVS_READ_I <= 1'b0;
    AVS_WRITE_I <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(16'(q), 16'(e));
  endtask
  // raise one source for len cycles, count pin-low and core-reset cycles; -1 skips a count
  task automatic fire(input logic [3:0] e, input int len, input logic [7:0] cause,
                      input int nlo, input int nhi);
    int lo, hi, n;
    lo = 0;
    hi = 0;
    @(posedge CLK_I);
    ev <= e;
    for (n = 1; n <= 200; n++) begin
      @(posedge CLK_I);
      if (n == len) ev <= 4'h0;
      lo += int'(!RST_PIN_OE_N_O);
      hi += int'(CORE_RESET_O);
      if (hi > 0 && !CORE_RESET_O) break;
    end
    if (nlo >= 0) chk(16'(lo), 16'(nlo));
    if (nhi >= 0) chk(16'(hi), 16'(nhi));
    rd(ADDR_RESET_CAUSE, cause);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic regs_check();
    rd(ADDR_RESET_CAUSE, 8'h80);
    rd(ADDR_BREAK_STATUS, 8'h00);
    INT_FLAGS1_I <= 8'hA7;
    INT_FLAGS3_I <= 8'hFF;
    rd(ADDR_INT_FIRST, 8'hA4);
    rd(ADDR_INT_THIRD, 8'h3F);
    bus(1'b1, ADDR_RESET_CAUSE, 8'hFF);
    rd(ADDR_RESET_CAUSE, 8'h80);
    rd(16'hFE02, 8'h00);
    chk(RESET_VECTOR_O, VEC_NORMAL);
    chk(16'(RST_PIN_O), 16'h0000);
    chk(16'(RST_PIN_OE_N_O), 16'h0001);
    chk(16'(BUS_CLK_SEL_O), 16'h0001);
    CLK_SRC_PLL_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    chk(16'(BUS_CLK_SEL_O), 16'h0002);
  endtask
  task automatic causes_check();
    fire(4'h2, 1, 8'h20, 32, 64);
    fire(4'h5, 1, 8'h10, 32, 64);
    fire(4'h6, 1, 8'h08, 32, 64);
    fire(4'h7, 1, 8'h08, 0, 0);
    bus(1'b1, ADDR_CONFIG, 8'h01);
    fire(4'h5, 1, 8'h08, 0, 0);
    fire(4'h4, 1, 8'h10, 32, 64);
    fire(4'h3, 40, 8'h02, -1, -1);
    fire(4'h9, 3, 8'h02, 0, 0);
    fire(4'h9, 4, 8'h40, 0, 32);
    fire(4'h1, 1, 8'h80, 32, 64);
  endtask
  task automatic monitor_check();
    MONITOR_MODE_I <= 1'b1;
    RST_PIN_VTST_I <= 1'b1;
    fire(4'h8, 1, 8'h04, 32, 64);
    chk(RESET_VECTOR_O, VEC_MONITOR);
    chk(16'(WDOG_DISABLE_O), 16'h0001);
    MONITOR_MODE_I <= 1'b0;
    repeat (3) @(posedge CLK_I);
    chk(16'(WDOG_DISABLE_O), 16'h0000);
    // in a break state only the reset pin's test voltage counts
    BREAK_STATE_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    chk(16'(WDOG_DISABLE_O), 16'h0001);
    RST_PIN_VTST_I <= 1'b0;
    IRQ_PIN_VTST_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    chk(16'(WDOG_DISABLE_O), 16'h0000);
    BREAK_STATE_I <= 1'b0;
    IRQ_PIN_VTST_I <= 1'b0;
  endtask
  task automatic brk_check();
    WAIT_BREAK_I <= 1'b1;
    @(posedge CLK_I);
    WAIT_BREAK_I <= 1'b0;
    rd(ADDR_BREAK_STATUS, 8'h02);
    bus(1'b1, ADDR_BREAK_STATUS, 8'hFF);
    rd(ADDR_BREAK_STATUS, 8'h02);
    bus(1'b1, ADDR_BREAK_STATUS, 8'h00);
    rd(ADDR_BREAK_STATUS, 8'h00);
  endtask
  // mask is set after the reset, since writes to it are dropped mid-sequence
  task automatic irq_check();
    fire(4'h2, 1, 8'h20, 32, 64);
    chk(RESET_VECTOR_O, VEC_NORMAL);
    chk(16'(IRQ_O), 16'h0000);
    bus(1'b1, ADDR_IRQ_MASK, 8'hFF);
    repeat (2) @(posedge CLK_I);
    chk(16'(IRQ_O), 16'h0001);
    bus(1'b1, ADDR_IRQ_STATUS, 8'hFF);
    repeat (2) @(posedge CLK_I);
    chk(16'(IRQ_O), 16'h0000);
    rd(ADDR_IRQ_STATUS, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    repeat (20) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    @(posedge CLK_I);
    // power-up stretch; the cycle ceiling ends this wait if it hangs
    while (CORE_RESET_O !== 1'b0) begin
      @(posedge CLK_I);
    end
    regs_check();
    causes_check();
    monitor_check();
    brk_check();
    irq_check();
    close_out();
  end
endmodule
bind system_reset_controller system_reset_controller_chk chk_i (.*);
